// ---- rtl/contact_filter.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "start_if_map.svh"

module contact_filter (
  // clock
  input  wire logic                  clk_sys_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  ce_in,
  // raw contacts
  input  wire logic [`CB_COUNT-1:0]  raw_in,
  // filtered levels
  contact_if.filt                    cif
);

  // ****************************************************************
  // per contact: two-stage synchroniser, then a stability filter
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `CB_COUNT; g++) begin : g_bit
      logic       meta_r;
      logic       sync_r;
      logic [3:0] cnt_r;
      logic       lvl_r;

      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
          meta_r <= 1'h0;
          sync_r <= 1'h0;
        end else if (ce_in) begin
          meta_r <= raw_in[g];
          sync_r <= meta_r;
        end
      end

      // level follows only after it stayed put for the whole window
      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
          cnt_r <= 4'h0;
          lvl_r <= 1'h0;
        end else if (ce_in) begin
          if (sync_r == lvl_r) begin
            cnt_r <= 4'h0;
          end else if (cnt_r == `DEBOUNCE_CYC - 4'h1) begin
            cnt_r <= 4'h0;
            lvl_r <= sync_r;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
      end

      assign cif.level[g] = lvl_r;
    end
  endgenerate

endmodule : contact_filter

`default_nettype wire

// ---- rtl/contact_if.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "start_if_map.svh"

interface contact_if;
  logic [`CB_COUNT-1:0]  level;
  logic                  sel_settled;
  logic                  sel_parity_ok;
  logic                  rst_settled;

  modport filt (output level);
  modport chk  (input level, output sel_settled, output sel_parity_ok, output rst_settled);
  modport core (input level, input sel_settled, input sel_parity_ok, input rst_settled);
endinterface : contact_if

`default_nettype wire

// ---- rtl/prog_start_if.sv ----
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

`include "start_if_map.svh"

// Notes on behaviour
// - preparation start with program reset item initialises all stored programs.
// - preparation items run one at a time; calibration only runs with motor power on.
// - full preparation takes about 5 s, about 1.3 s without calibration.
// - program number acted on only in external mode; else error and motor off.
// - number bits plus parity; closed contact is one; ones count is odd.
// - selectable programs 0 to 127 on seven weight bits plus parity.
// - number settled 1 ms before start and held until motion; else error.
// - start recognised only on an inactive to active transition.
// - start edge when idle samples number, runs one cycle, then rests.
// - start low at least 50 ms before its rise or no cycle launches.
// - start after step stop resumes at the following step, ends at cycle end.
// - start after instantaneous stop resumes the interrupted step itself.
// - reset with number and start abandons suspension and restarts from step one.
// - start acknowledge rises when the program begins; partner then drops start.
// - in-operation, acknowledge, cycle-end change in that order within 100 ms.
// - initialisation lasts up to one second; inputs ignored meanwhile.
// - with program reset the selected program runs from its first step.
// - calibration item refused while motor power is off.
module prog_start_if
  import start_if_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `SETTLE_MS * `CYC_PER_MS,
  parameter int unsigned GAP_CYC    = `START_GAP_MS * `CYC_PER_MS,
  parameter int unsigned SEQ_CYC    = `OUT_SEQ_MS * `CYC_PER_MS,
  parameter int unsigned INIT_CYC   = `INIT_MS * `CYC_PER_MS,
  parameter int unsigned PREP_CYC   = `PREP_MAX_MS * `CYC_PER_MS
) (
  // clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   ce_in,
  // contacts from the sequence controller
  input  wire logic                   prep_start_in,
  input  wire logic                   motor_on_item_in,
  input  wire logic                   cal_item_in,
  input  wire logic                   full_speed_item_in,
  input  wire logic                   ext_mode_item_in,
  input  wire logic                   prog_reset_in,
  input  wire logic                   enable_auto_in,
  input  wire logic [`PROG_BITS-1:0]  prog_num_in,
  input  wire logic                   prog_parity_in,
  input  wire logic                   prog_start_in,
  // status to the sequence controller
  output logic                        ext_mode_out,
  output logic                        in_operation_out,
  output logic                        start_ack_out,
  output logic                        cycle_end_out,
  output logic                        motor_power_out,
  output logic                        error_out,
  output err_type                     error_code_out,
  // motion core
  input  wire logic                   power_on_done_in,
  input  wire logic                   item_done_in,
  input  wire logic                   cal_done_in,
  input  wire logic                   motion_started_in,
  input  wire logic                   cycle_done_in,
  input  wire logic                   step_stopped_in,
  input  wire logic                   inst_stopped_in,
  output logic                        item_req_out,
  output prep_item_type               item_sel_out,
  output logic                        init_all_out,
  output logic                        launch_out,
  output logic [`PROG_BITS-1:0]       launch_prog_out,
  output resume_type                  launch_from_out,
  // register port
  input  wire logic [3:0]             reg_addr_in,
  input  wire logic [31:0]            reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic [31:0]                 reg_rdata_out
);

  localparam logic [31:0] GAP_LIM  = 32'(GAP_CYC);
  localparam logic [31:0] SEQ_LIM  = 32'(SEQ_CYC);
  localparam logic [31:0] INIT_LIM = 32'(INIT_CYC);
  localparam logic [31:0] PREP_LIM = 32'(PREP_CYC);

  contact_if cif ();

  logic [`CB_COUNT-1:0] raw;
  logic                 start_d_r;
  logic                 prep_d_r;
  logic [31:0]          gap_cnt_r;
  logic [31:0]          seq_cnt_r;
  run_state_type        run_r;
  prep_state_type       prep_r;
  resume_type           susp_r;
  logic [4:0]           pend_r;
  logic [31:0]          prep_cnt_r;
  logic                 init_busy_r;
  logic                 en_r;
  logic                 run_err_r;
  err_type              run_code_r;
  logic                 prep_err_r;
  logic                 clr_req;
  logic                 start_rise;
  logic                 prep_rise;
  logic [`PROG_BITS-1:0] num;

  assign raw = {prog_start_in, prog_parity_in, prog_num_in, enable_auto_in, prog_reset_in,
                ext_mode_item_in, full_speed_item_in, cal_item_in, motor_on_item_in,
                prep_start_in};
  assign num = cif.level[`CB_NUM_HI:`CB_NUM_LO];

  contact_filter u_filter (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .raw_in     (raw),
    .cif        (cif.filt)
  );

  select_check #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_check (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .cif        (cif.chk)
  );

  // ****************************************************************
  // edge detection and start low-time measurement
  // ****************************************************************
  assign start_rise = cif.level[`CB_START] & ~start_d_r;
  assign prep_rise  = cif.level[`CB_PREP] & ~prep_d_r;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      start_d_r <= 1'h0;
      prep_d_r  <= 1'h0;
      gap_cnt_r <= 32'h0;
    end else if (ce_in) begin
      start_d_r <= cif.level[`CB_START];
      prep_d_r  <= cif.level[`CB_PREP];
      if (cif.level[`CB_START]) begin
        gap_cnt_r <= 32'h0;
      end else if (gap_cnt_r < GAP_LIM) begin
        gap_cnt_r <= gap_cnt_r + 32'h1;
      end
    end
  end

  // ****************************************************************
  // program start sequencing
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      run_r            <= R_IDLE;
      susp_r           <= FROM_FIRST;
      in_operation_out <= 1'h0;
      cycle_end_out    <= 1'h0;
      launch_out       <= 1'h0;
      launch_prog_out  <= '0;
      launch_from_out  <= FROM_FIRST;
      run_err_r        <= 1'h0;
      run_code_r       <= ERR_NONE;
      seq_cnt_r        <= 32'h0;
    end else if (ce_in) begin
      launch_out <= 1'h0;
      run_err_r  <= 1'h0;
      if (init_all_out) begin
        susp_r <= FROM_FIRST;
      end
      unique case (run_r)
        R_IDLE: begin
          if (start_rise && en_r && !init_busy_r) begin
            if (!ext_mode_out) begin
              run_err_r  <= 1'h1;
              run_code_r <= ERR_WRONG_MODE;
            end else if (gap_cnt_r < GAP_LIM) begin
              run_r <= R_IDLE;
            end else if (!cif.sel_settled) begin
              run_err_r  <= 1'h1;
              run_code_r <= ERR_SELECT_TIME;
            end else if (!cif.sel_parity_ok) begin
              run_err_r  <= 1'h1;
              run_code_r <= ERR_PARITY;
            end else begin
              launch_prog_out  <= num;
              launch_from_out  <= (cif.level[`CB_RESET] && cif.rst_settled) ?
                                  FROM_FIRST : susp_r;
              in_operation_out <= 1'h1;
              seq_cnt_r        <= 32'h0;
              run_r            <= R_ACK;
            end
          end
        end
        R_ACK: begin
          launch_out <= 1'h1;
          run_r      <= R_END;
        end
        R_END: begin
          cycle_end_out <= 1'h0;
          run_r         <= R_WAIT;
        end
        R_WAIT: begin
          seq_cnt_r <= seq_cnt_r + 32'h1;
          if (num != launch_prog_out || seq_cnt_r >= SEQ_LIM) begin
            run_err_r        <= 1'h1;
            run_code_r       <= ERR_SELECT_TIME;
            in_operation_out <= 1'h0;
            run_r            <= R_IDLE;
          end else if (motion_started_in) begin
            run_r <= R_RUN;
          end
        end
        R_RUN: begin
          if (cycle_done_in) begin
            in_operation_out <= 1'h0;
            cycle_end_out    <= 1'h1;
            susp_r           <= FROM_FIRST;
            run_r            <= R_IDLE;
          end else if (step_stopped_in) begin
            in_operation_out <= 1'h0;
            susp_r           <= FROM_NEXT;
            run_r            <= R_IDLE;
          end else if (inst_stopped_in) begin
            in_operation_out <= 1'h0;
            susp_r           <= FROM_SAME;
            run_r            <= R_IDLE;
          end
        end
        default: begin
          run_r <= R_IDLE;
        end
      endcase
    end
  end

  // acknowledge rises together with the launch pulse, falls when the start contact opens
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      start_ack_out <= 1'h0;
    end else if (ce_in) begin
      if (run_r == R_ACK) begin
        start_ack_out <= 1'h1;
      end else if (!cif.level[`CB_START]) begin
        start_ack_out <= 1'h0;
      end
    end
  end

  // ****************************************************************
  // preparation start: items one at a time, lowest first
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      prep_r          <= P_IDLE;
      pend_r          <= 5'h0;
      prep_cnt_r      <= 32'h0;
      item_req_out    <= 1'h0;
      item_sel_out    <= ITEM_MOTOR;
      init_all_out    <= 1'h0;
      init_busy_r     <= 1'h0;
      motor_power_out <= 1'h0;
      ext_mode_out    <= 1'h0;
      prep_err_r      <= 1'h0;
    end else if (ce_in) begin
      item_req_out <= 1'h0;
      init_all_out <= 1'h0;
      prep_err_r   <= 1'h0;
      if (run_err_r) begin
        motor_power_out <= 1'h0;
        if (run_code_r == ERR_SELECT_TIME) begin
          ext_mode_out <= 1'h0;
        end
      end
      if (!cif.level[`CB_AUTO]) begin
        ext_mode_out <= 1'h0;
      end
      if (prep_r != P_IDLE) begin
        prep_cnt_r <= prep_cnt_r + 32'h1;
      end
      if (prep_r != P_IDLE && prep_r != P_INIT && prep_cnt_r >= PREP_LIM) begin
        prep_err_r <= 1'h1;
        pend_r     <= 5'h0;
        prep_r     <= P_IDLE;
      end else begin
        unique case (prep_r)
          P_IDLE: begin
            prep_cnt_r <= 32'h0;
            if (prep_rise && en_r && power_on_done_in && !init_busy_r) begin
              pend_r <= {cif.level[`CB_RESET] & cif.rst_settled, cif.level[`CB_EXT],
                         cif.level[`CB_SPEED], cif.level[`CB_CAL], cif.level[`CB_MOTOR]};
              prep_r <= P_PICK;
            end
          end
          P_PICK: begin
            if (pend_r[0]) begin
              item_sel_out <= ITEM_MOTOR;
              item_req_out <= 1'h1;
              prep_r       <= P_WAIT;
            end else if (pend_r[1]) begin
              if (motor_power_out) begin
                item_sel_out <= ITEM_CAL;
                item_req_out <= 1'h1;
                prep_r       <= P_WAIT;
              end else begin
                pend_r[1] <= 1'h0;
              end
            end else if (pend_r[2]) begin
              item_sel_out <= ITEM_SPEED;
              item_req_out <= 1'h1;
              prep_r       <= P_WAIT;
            end else if (pend_r[3]) begin
              if (motor_power_out && cal_done_in) begin
                item_sel_out <= ITEM_EXT;
                item_req_out <= 1'h1;
                prep_r       <= P_WAIT;
              end else begin
                pend_r[3] <= 1'h0;
              end
            end else if (pend_r[4]) begin
              pend_r       <= 5'h0;
              item_sel_out <= ITEM_RESET;
              init_all_out <= 1'h1;
              init_busy_r  <= 1'h1;
              prep_cnt_r   <= 32'h0;
              prep_r       <= P_INIT;
            end else begin
              prep_r <= P_IDLE;
            end
          end
          P_WAIT: begin
            if (item_done_in) begin
              pend_r[item_sel_out] <= 1'h0;
              if (item_sel_out == ITEM_MOTOR) begin
                motor_power_out <= 1'h1;
              end
              if (item_sel_out == ITEM_EXT) begin
                ext_mode_out <= 1'h1;
              end
              prep_r <= P_PICK;
            end
          end
          P_INIT: begin
            if (prep_cnt_r >= INIT_LIM - 32'h1) begin
              init_busy_r <= 1'h0;
              prep_r      <= P_IDLE;
            end
          end
          default: begin
            prep_r <= P_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // sticky error, set wins over software clear
  // ****************************************************************
  assign clr_req = reg_wr_in && reg_addr_in == `REG_CTRL && reg_wdata_in[`CTRL_CLR_BIT];

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      error_out      <= 1'h0;
      error_code_out <= ERR_NONE;
    end else if (ce_in) begin
      if (run_err_r) begin
        error_out      <= 1'h1;
        error_code_out <= run_code_r;
      end else if (prep_err_r) begin
        error_out      <= 1'h1;
        error_code_out <= ERR_PREP_TIMEOUT;
      end else if (clr_req) begin
        error_out      <= 1'h0;
        error_code_out <= ERR_NONE;
      end
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      en_r <= `CTRL_RST;
    end else if (ce_in && reg_wr_in && reg_addr_in == `REG_CTRL) begin
      en_r <= reg_wdata_in[`CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0;
    end else if (ce_in) begin
      reg_rdata_out <= 32'h0;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          `REG_CTRL:   reg_rdata_out <= {31'h0, en_r};
          `REG_STATUS: reg_rdata_out <= {20'h0, error_code_out, error_out, init_busy_r,
                                         motor_power_out, cycle_end_out, start_ack_out,
                                         in_operation_out, ext_mode_out, susp_r};
          `REG_PROG:   reg_rdata_out <= {25'h0, launch_prog_out};
          default:     reg_rdata_out <= 32'h0;
        endcase
      end
    end
  end

endmodule : prog_start_if

`default_nettype wire

// ---- rtl/select_check.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "start_if_map.svh"

module select_check #(
  parameter int unsigned SETTLE_CYC = `SETTLE_MS * `CYC_PER_MS
) (
  // clock
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic ce_in,
  // filtered levels in, checks out
  contact_if.chk    cif
);

  localparam logic [31:0] SETTLE_LIM = 32'(SETTLE_CYC);

  logic [`PROG_BITS:0] snap_r;
  logic [31:0]         sel_cnt_r;
  logic [31:0]         rst_cnt_r;
  logic [`PROG_BITS:0] word;

  assign word = {cif.level[`CB_PARITY], cif.level[`CB_NUM_HI:`CB_NUM_LO]};

  // ****************************************************************
  // program number plus parity: age since last change
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      snap_r    <= '0;
      sel_cnt_r <= 32'h0;
    end else if (ce_in) begin
      snap_r <= word;
      if (word != snap_r) begin
        sel_cnt_r <= 32'h0;
      end else if (sel_cnt_r < SETTLE_LIM) begin
        sel_cnt_r <= sel_cnt_r + 32'h1;
      end
    end
  end

  // ****************************************************************
  // program reset: time held
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rst_cnt_r <= 32'h0;
    end else if (ce_in) begin
      if (!cif.level[`CB_RESET]) begin
        rst_cnt_r <= 32'h0;
      end else if (rst_cnt_r < SETTLE_LIM) begin
        rst_cnt_r <= rst_cnt_r + 32'h1;
      end
    end
  end

  assign cif.sel_settled   = (sel_cnt_r >= SETTLE_LIM);
  assign cif.sel_parity_ok = ^snap_r;
  assign cif.rst_settled   = (rst_cnt_r >= SETTLE_LIM);

endmodule : select_check

`default_nettype wire

// ---- rtl/start_if_map.svh ----
`ifndef START_IF_MAP_SVH
`define START_IF_MAP_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_HZ         100000000
`define CYC_PER_MS     (`CLK_HZ / 1000)
`define SETTLE_MS      1
`define START_GAP_MS   50
`define OUT_SEQ_MS     100
`define INIT_MS        1000
`define PREP_MAX_MS    5000
`define DEBOUNCE_CYC   4'h8

// ****************************************************************
// contact bit positions inside the filtered bus
// ****************************************************************
`define CB_PREP        0
`define CB_MOTOR       1
`define CB_CAL         2
`define CB_SPEED       3
`define CB_EXT         4
`define CB_RESET       5
`define CB_AUTO        6
`define CB_NUM_LO      7
`define CB_NUM_HI      13
`define CB_PARITY      14
`define CB_START       15
`define CB_COUNT       16
`define PROG_BITS      7

// ****************************************************************
// register offsets, fields and reset values
// ****************************************************************
`define REG_CTRL       4'h0
`define REG_STATUS     4'h4
`define REG_PROG       4'h8
`define CTRL_EN_BIT    0
`define CTRL_CLR_BIT   1
`define CTRL_RST       1'h1

`endif

// ---- rtl/start_if_pkg.sv ----
package start_if_pkg;

  typedef enum logic [2:0] {
    ITEM_MOTOR = 3'h0,
    ITEM_CAL   = 3'h1,
    ITEM_SPEED = 3'h2,
    ITEM_EXT   = 3'h3,
    ITEM_RESET = 3'h4
  } prep_item_type;

  typedef enum logic [1:0] {
    FROM_FIRST = 2'h0,
    FROM_NEXT  = 2'h1,
    FROM_SAME  = 2'h2
  } resume_type;

  typedef enum logic [2:0] {
    ERR_NONE         = 3'h0,
    ERR_WRONG_MODE   = 3'h1,
    ERR_SELECT_TIME  = 3'h2,
    ERR_PARITY       = 3'h3,
    ERR_PREP_TIMEOUT = 3'h4
  } err_type;

  typedef enum logic [2:0] {
    R_IDLE = 3'h0,
    R_ACK  = 3'h1,
    R_END  = 3'h2,
    R_WAIT = 3'h3,
    R_RUN  = 3'h4
  } run_state_type;

  typedef enum logic [1:0] {
    P_IDLE = 2'h0,
    P_PICK = 2'h1,
    P_WAIT = 2'h2,
    P_INIT = 2'h3
  } prep_state_type;

endpackage : start_if_pkg

// ---- tb/motion_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module motion_model
  import start_if_pkg::*;
(
  input  wire logic          clk_sys_in, launch_out, item_req_out,
  input  wire prep_item_type item_sel_out,
  input  wire logic [1:0]    stop_kind,
  output logic               power_on_done_in, item_done_in, cal_done_in, motion_started_in,
  output logic               cycle_done_in, step_stopped_in, inst_stopped_in
);
  int t = 0;
  int q = 0;
  initial begin
    power_on_done_in = 1'b1;
    {item_done_in, cal_done_in, motion_started_in} = 3'h0;
    {cycle_done_in, step_stopped_in, inst_stopped_in} = 3'h0;
  end
  // one answer per item request, a few cycles later
  always @(posedge clk_sys_in) begin
    q <= item_req_out ? 4 : (q > 0 ? q - 1 : 0);
    item_done_in <= q == 1;
    if (q == 1 && item_sel_out == ITEM_CAL) cal_done_in <= 1'b1;
    t <= launch_out ? 12 : (t > 0 ? t - 1 : 0);
    motion_started_in <= t == 9;
    cycle_done_in <= t == 1 && stop_kind == 2'h0;
    step_stopped_in <= t == 1 && stop_kind == 2'h1;
    inst_stopped_in <= t == 1 && stop_kind == 2'h2;
  end
endmodule : motion_model
`default_nettype wire

// ---- tb/prog_start_if_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "start_if_map.svh"
module prog_start_if_bench;
  import start_if_pkg::*;
  logic clk_sys_in, sys_rst_in, ce_in, prep_start_in, motor_on_item_in, cal_item_in;
  logic full_speed_item_in, ext_mode_item_in, prog_reset_in, enable_auto_in, prog_parity_in;
  logic prog_start_in, reg_wr_in, reg_rd_in, power_on_done_in, item_done_in, cal_done_in;
  logic motion_started_in, cycle_done_in, step_stopped_in, inst_stopped_in, ext_mode_out;
  logic in_operation_out, start_ack_out, cycle_end_out, motor_power_out, error_out;
  logic item_req_out, init_all_out, launch_out;
  logic [`PROG_BITS-1:0] prog_num_in, launch_prog_out;
  logic [3:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, rd;
  logic [1:0] stop_kind;
  err_type error_code_out;
  prep_item_type item_sel_out;
  resume_type launch_from_out;
  int seed = 32'hB765C462;
  int miscompares = 0;
  int comparisons = 0;
  prog_start_if #(.SETTLE_CYC(20), .GAP_CYC(40), .SEQ_CYC(100), .INIT_CYC(50),
    .PREP_CYC(500)) dut (.*);
  motion_model far (.*);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cy
  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : ck
  task automatic rg(input logic [3:0] a, input logic w, input logic [31:0] d);
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} <= {a, d, w, !w};
    cy(1);
    {reg_wr_in, reg_rd_in} <= 2'h0;
    #1;
    rd = reg_rdata_out;
    cy(1);
  endtask : rg
  task automatic run(input logic [1:0] k, input logic r, input logic bad, input resume_type f);
    logic [`PROG_BITS-1:0] n;
    n = 7'($random(seed));
    prog_num_in <= n;
    prog_parity_in <= ~^n ^ bad;
    prog_reset_in <= r;
    stop_kind <= k;
    cy(60);
    prog_start_in <= 1'b1;
    for (int i = 0; i < 30 && start_ack_out !== 1'b1; i++) cy(1);
    if (bad) ck(error_code_out, ERR_PARITY);
    else begin
      ck(launch_prog_out, n);
      ck(launch_from_out, f);
    end
    {prog_start_in, prog_reset_in} <= 2'h0;
    for (int i = 0; i < 40 && in_operation_out !== 1'b0; i++) cy(1);
    ck(cycle_end_out, k == 2'h0);
    $display("run test done");
  endtask : run
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #200000;
    miscompares++;
    summarize;
  end
  initial begin
    {sys_rst_in, ce_in, enable_auto_in, prep_start_in, motor_on_item_in} = 5'h1C;
    {cal_item_in, full_speed_item_in, ext_mode_item_in, prog_reset_in} = 4'h0;
    {prog_parity_in, prog_start_in, reg_wr_in, reg_rd_in} = 4'h0;
    {prog_num_in, reg_addr_in, reg_wdata_in, stop_kind} = '0;
    cy(2);
    sys_rst_in <= 1'b0;
    rg(`REG_CTRL, 1'b0, 32'h0);
    ck(rd, 32'h1);
    rg(4'hC, 1'b0, 32'h0);
    ck(rd, 32'h0);
    prog_reset_in <= 1'b1;
    {motor_on_item_in, cal_item_in, full_speed_item_in, ext_mode_item_in} <= 4'hF;
    cy(40);
    prep_start_in <= 1'b1;
    for (int i = 0; i < 400 && ext_mode_out !== 1'b1; i++) cy(1);
    {prep_start_in, motor_on_item_in, cal_item_in, full_speed_item_in} <= 4'h0;
    {ext_mode_item_in, prog_reset_in} <= 2'h0;
    ck(motor_power_out, 1'b1);
    ck(ext_mode_out, 1'b1);
    cy(80);
    $display("prep test done");
    run(2'h1, 1'b0, 1'b0, FROM_FIRST);
    run(2'h2, 1'b0, 1'b0, FROM_NEXT);
    run(2'h1, 1'b1, 1'b0, FROM_FIRST);
    run(2'h0, 1'b0, 1'b0, FROM_NEXT);
    run(2'h0, 1'b0, 1'b0, FROM_FIRST);
    prog_start_in <= 1'b1;
    cy(30);
    ck(start_ack_out, 1'b0);
    prog_start_in <= 1'b0;
    run(2'h0, 1'b0, 1'b1, FROM_FIRST);
    {prep_start_in, motor_on_item_in} <= 2'h3;
    rg(`REG_CTRL, 1'b1, 32'h3);
    rg(`REG_STATUS, 1'b0, 32'h0);
    ck(rd[11:8], 4'h0);
    enable_auto_in <= 1'b0;
    cy(60);
    ck(ext_mode_out, 1'b0);
    prog_start_in <= 1'b1;
    cy(30);
    ck(error_code_out, ERR_WRONG_MODE);
    ck(motor_power_out, 1'b0);
    $display("mode test done");
    summarize;
  end
endmodule : prog_start_if_bench
`default_nettype wire

// ---- tb/prog_start_if_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "start_if_map.svh"
module prog_start_if_chk
  import start_if_pkg::*;
(
  input wire logic clk_sys_in, sys_rst_in, prog_parity_in, prog_start_in, launch_out,
  input wire logic [`PROG_BITS-1:0] prog_num_in,
  input wire logic ext_mode_out, in_operation_out, start_ack_out, cycle_end_out,
  input wire logic motor_power_out, error_out, item_req_out, init_all_out,
  input wire err_type error_code_out,
  input wire prep_item_type item_sel_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_launch;
    launch_out ##1 (start_ack_out && !cycle_end_out);
  endsequence
  a_out_order: assert property ($rose(in_operation_out) |=> s_launch)
    else $error("status outputs out of order");
  a_ext_needed: assert property (launch_out |-> ext_mode_out)
    else $error("launch outside ext mode");
  a_parity_odd: assert property (launch_out |-> ^{prog_num_in, prog_parity_in})
    else $error("launch on even parity");
  a_err_coded: assert property ($rose(error_out) |-> ##[0:1] error_code_out != ERR_NONE)
    else $error("error without code");
  a_mode_motor: assert property ($changed(error_code_out) && error_code_out == ERR_WRONG_MODE
    |-> ##[0:2] !motor_power_out) else $error("motor on after mode error");
  a_cal_motor: assert property (item_req_out && item_sel_out == ITEM_CAL |-> motor_power_out)
    else $error("calibration without motor");
  a_init_item: assert property (init_all_out |-> item_sel_out == ITEM_RESET)
    else $error("init outside reset item");
  a_ack_release: assert property ($fell(start_ack_out) |-> !prog_start_in)
    else $error("ack dropped with start high");
endmodule : prog_start_if_chk
bind prog_start_if prog_start_if_chk chk (.*);
`default_nettype wire
